//--- include/tps_defs.vh
`ifndef TPS_DEFS_VH
`define TPS_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TPS_ADDR_W 4
`define TPS_OFF_PER 4'h0
`define TPS_OFF_TPS 4'h1
`define TPS_OFF_MODE 4'h2
`define TPS_OFF_STAT 4'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPS_PER_RST 8'h00
`define TPS_TPS_RST 16'h0000
`define TPS_MODE_RST 16'h0001

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPS_PER_GATE_BIT 0
`define TPS_PRS0_LO 0
`define TPS_PRS1_LO 4
`define TPS_PRS2_LO 8
`define TPS_PRS3_LO 12
`define TPS_MODE_CKS_HI 15
`define TPS_MODE_CKS_LO 14
`define TPS_MODE_CCS_BIT 12
`define TPS_MODE_WMASK 16'hD7CF

// ----------------------------------------
// Clock select and mode codes
// ----------------------------------------
`define TPS_CKS_CK0 2'h0
`define TPS_CKS_CK2 2'h1
`define TPS_CKS_CK1 2'h2
`define TPS_CKS_CK3 2'h3
`define TPS_MD_INTERVAL 3'h0
`define TPS_MD_CAPTURE 3'h2
`define TPS_MD_EVENT 3'h3
`define TPS_MD_ONECOUNT 3'h4
`define TPS_MD_CAP_ONE 3'h6

`define TPS_DIV_W 15

`endif

//--- src/tps_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser; level changes once stages two and three agree
module tps_sync (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // Pin
  input wire i_pin,
  output reg o_level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end
endmodule // tps_sync

//--- src/tps_top.v
`timescale 1ns/1ps
`include "tps_defs.vh"

module tps_top (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // Register port
  input wire [`TPS_ADDR_W-1:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Timer input pin
  input wire i_chan_zero_timer_input,
  // Clock outputs: gate level, then one-cycle tick enables
  output reg o_timer_unit_clock_gate,
  output reg o_operation_clock_zero,
  output reg o_operation_clock_one,
  output reg o_operation_clock_two,
  output reg o_operation_clock_three,
  output reg o_chan_zero_op_clock,
  output reg o_chan_zero_count_clock,
  // Mode decode
  output reg o_chan_zero_count_up,
  output reg o_chan_zero_mode_bad
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Tick when the low n bits of the free counter are all ones
  function tick_of;
    input [`TPS_DIV_W-1:0] cnt;
    input [3:0] prs;
    reg [`TPS_DIV_W-1:0] mask;
    begin
      mask = ({`TPS_DIV_W{1'b1}} >> (4'hF - prs));
      if (prs == 4'h0) begin
        tick_of = 1'b1;
      end else begin
        tick_of = ((cnt & mask) == ({`TPS_DIV_W{1'b1}} & mask));
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] per_reg;
  reg [15:0] tps_reg;
  reg [15:0] mode_reg;
  reg [`TPS_DIV_W-1:0] div_reg;
  reg edge_prev_reg;
  wire pin_level;
  wire gate;
  wire ck0;
  wire ck1;
  wire ck2;
  wire ck3;
  reg sel_ck;
  reg pin_edge;
  reg [2:0] md;
  reg up_next;
  reg bad_next;

  assign gate = per_reg[`TPS_PER_GATE_BIT];

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      per_reg <= `TPS_PER_RST;
      tps_reg <= `TPS_TPS_RST;
      mode_reg <= `TPS_MODE_RST;
    end else if (i_wr) begin
      case (i_addr)
        `TPS_OFF_PER: begin
          per_reg <= i_wdata[7:0];
        end
        `TPS_OFF_TPS: begin
          tps_reg <= i_wdata;
        end
        `TPS_OFF_MODE: begin
          mode_reg <= i_wdata & `TPS_MODE_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `TPS_OFF_PER: begin
          o_rdata <= {8'h00, per_reg};
        end
        `TPS_OFF_TPS: begin
          o_rdata <= tps_reg;
        end
        `TPS_OFF_MODE: begin
          o_rdata <= mode_reg;
        end
        `TPS_OFF_STAT: begin
          o_rdata <= {13'h0000, o_chan_zero_mode_bad, o_chan_zero_count_up, gate};
        end
        default: begin
          o_rdata <= 16'h0000;
        end
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_reg <= {`TPS_DIV_W{1'b0}};
    end else if (gate) begin
      div_reg <= div_reg + 15'h0001;
    end else begin
      div_reg <= {`TPS_DIV_W{1'b0}};
    end
  end

  assign ck0 = gate & tick_of(div_reg, tps_reg[`TPS_PRS0_LO+3:`TPS_PRS0_LO]);
  assign ck1 = gate & tick_of(div_reg, tps_reg[`TPS_PRS1_LO+3:`TPS_PRS1_LO]);
  assign ck2 = gate & tick_of(div_reg, {2'b00, tps_reg[`TPS_PRS2_LO+1:`TPS_PRS2_LO]});
  assign ck3 = gate & tick_of(div_reg,
                              {1'b1, tps_reg[`TPS_PRS3_LO+1:`TPS_PRS3_LO], 1'b0});

  // ----------------------------------------
  // Channel clock selection and pin edge detection
  // ----------------------------------------
  tps_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_chan_zero_timer_input),
    .o_level(pin_level)
  );

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      edge_prev_reg <= 1'b0;
    end else begin
      edge_prev_reg <= pin_level;
    end
  end

  always @* begin
    case (mode_reg[`TPS_MODE_CKS_HI:`TPS_MODE_CKS_LO])
      `TPS_CKS_CK0: begin
        sel_ck = ck0;
      end
      `TPS_CKS_CK2: begin
        sel_ck = ck2;
      end
      `TPS_CKS_CK1: begin
        sel_ck = ck1;
      end
      `TPS_CKS_CK3: begin
        sel_ck = ck3;
      end
      default: begin
        sel_ck = ck0;
      end
    endcase
    case (mode_reg[7:6])
      2'h0: begin
        pin_edge = ~pin_level & edge_prev_reg;
      end
      2'h1: begin
        pin_edge = pin_level & ~edge_prev_reg;
      end
      default: begin
        pin_edge = pin_level ^ edge_prev_reg;
      end
    endcase
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  always @* begin
    md = mode_reg[3:1];
    up_next = 1'b0;
    bad_next = 1'b0;
    case (md)
      `TPS_MD_INTERVAL: begin
        up_next = 1'b0;
      end
      `TPS_MD_CAPTURE: begin
        up_next = 1'b1;
      end
      `TPS_MD_EVENT: begin
        bad_next = mode_reg[0];
      end
      `TPS_MD_ONECOUNT: begin
        up_next = 1'b0;
      end
      `TPS_MD_CAP_ONE: begin
        up_next = 1'b1;
        bad_next = mode_reg[0];
      end
      default: begin
        bad_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Gate level and tick outputs
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_timer_unit_clock_gate <= 1'b0;
    end else begin
      o_timer_unit_clock_gate <= gate;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_operation_clock_zero <= 1'b0;
    end else begin
      o_operation_clock_zero <= ck0;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_operation_clock_one <= 1'b0;
    end else begin
      o_operation_clock_one <= ck1;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_operation_clock_two <= 1'b0;
    end else begin
      o_operation_clock_two <= ck2;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_operation_clock_three <= 1'b0;
    end else begin
      o_operation_clock_three <= ck3;
    end
  end

  // ----------------------------------------
  // Channel outputs
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chan_zero_op_clock <= 1'b0;
    end else begin
      o_chan_zero_op_clock <= sel_ck;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chan_zero_count_clock <= 1'b0;
    end else begin
      if (mode_reg[`TPS_MODE_CCS_BIT]) begin
        o_chan_zero_count_clock <= gate & pin_edge;
      end else begin
        o_chan_zero_count_clock <= sel_ck;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chan_zero_count_up <= 1'b0;
    end else begin
      o_chan_zero_count_up <= up_next;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chan_zero_mode_bad <= 1'b0;
    end else begin
      o_chan_zero_mode_bad <= bad_next;
    end
  end
endmodule // tps_top

//--- verif/tps_checker.sv
`timescale 1ns/1ps
module tps_checker (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire i_chan_zero_timer_input,
  input wire o_timer_unit_clock_gate,
  input wire o_operation_clock_zero,
  input wire o_operation_clock_one,
  input wire o_operation_clock_two,
  input wire o_operation_clock_three,
  input wire o_chan_zero_count_clock,
  input wire o_chan_zero_count_up,
  input wire o_chan_zero_mode_bad
);
  localparam [15:0] LEG = 16'h1373;
  localparam [15:0] UPM = 16'h1030;
  reg [15:0] md_reg;
  reg [3:0] ps_reg;
  reg [2:0] pw_reg;
  reg [2:0] mw_reg;
  reg [16:0] gap_reg;
  reg ok_reg;
  wire wp = i_wr && i_addr == 4'h1;
  wire ck0 = o_operation_clock_zero;
  wire legal = LEG[md_reg[3:0]];
  // ----------
  // Write shadows
  // ----------
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      md_reg <= 16'h0001;
      ps_reg <= 4'h0;
      pw_reg <= 3'h0;
      mw_reg <= 3'h0;
      gap_reg <= 17'h00000;
      ok_reg <= 1'b0;
    end else begin
      if (i_wr && i_addr == 4'h2) begin
        md_reg <= i_wdata;
        mw_reg <= 3'h0;
      end else if (mw_reg != 3'h7) begin
        mw_reg <= mw_reg + 3'h1;
      end
      if (wp)
        ps_reg <= i_wdata[3:0];
      pw_reg <= wp ? 3'h0 : (pw_reg == 3'h7 ? pw_reg : pw_reg + 3'h1);
      gap_reg <= ck0 ? 17'h00001 : gap_reg + 17'h00001;
      ok_reg <= (wp || !o_timer_unit_clock_gate) ? 1'b0 : ((ck0 && pw_reg > 3'h5) | ok_reg);
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  a_gate_follow: assert property (
    i_wr && i_addr == 4'h0 |-> ##2 o_timer_unit_clock_gate == $past(i_wdata[0], 2))
    else $error("gate does not follow enable bit");
  a_ck0_period: assert property (
    ck0 && ok_reg |-> gap_reg == (17'h00001 << ps_reg))
    else $error("clock zero period wrong");
  a_fixed_zero: assert property (
    i_rd && i_addr == 4'h2 |=> (o_rdata & 16'h2830) == 16'h0000)
    else $error("fixed mode bits not zero");
  a_pin_quiet: assert property (
    (md_reg[12] && !i_chan_zero_timer_input)[*8] ##1
    (md_reg[12] && !i_chan_zero_timer_input)[*4] |-> !o_chan_zero_count_clock)
    else $error("count tick without pin edge");
  a_mode_up: assert property (
    mw_reg == 3'h7 && legal |-> o_chan_zero_count_up == UPM[md_reg[3:0]])
    else $error("count direction wrong");
  a_mode_bad: assert property (
    mw_reg == 3'h7 |-> o_chan_zero_mode_bad == !legal)
    else $error("prohibited mode flag wrong");
  a_gated_still: assert property (
    !o_timer_unit_clock_gate && $past(!o_timer_unit_clock_gate) |->
    !(ck0 || o_operation_clock_one || o_operation_clock_two || o_operation_clock_three))
    else $error("tick while clock gated");
endmodule // tps_checker

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam [15:0] LEG = 16'h1373;
  localparam [15:0] UPM = 16'h1030;
  reg i_sys_clk = 1'b0;
  reg i_arst_n = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [15:0] i_wdata = 16'h0000;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_chan_zero_timer_input = 1'b0;
  wire [15:0] o_rdata;
  wire [3:0] ck;
  wire gate, op, cc, up, bad;
  integer miscompares = 0;
  integer tests_run = 0;
  integer n [0:5];
  integer i, j, k;
  reg [3:0] m;
  always #5 i_sys_clk = ~i_sys_clk;
  tps_top dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_chan_zero_timer_input(i_chan_zero_timer_input), .o_timer_unit_clock_gate(gate),
    .o_operation_clock_zero(ck[0]), .o_operation_clock_one(ck[1]),
    .o_operation_clock_two(ck[2]), .o_operation_clock_three(ck[3]),
    .o_chan_zero_op_clock(op), .o_chan_zero_count_clock(cc),
    .o_chan_zero_count_up(up), .o_chan_zero_mode_bad(bad));
  task chk(input ok, input [63:0] s);
    begin
      tests_run = tests_run + 1;
      if (!ok) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t %0s", $time, s);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata === e, "rdata");
    end
  endtask
  // Counts ticks over c cycles
  task run(input integer c);
    begin
      for (j = 0; j < 6; j = j + 1)
        n[j] = 0;
      repeat (c) begin
        @(posedge i_sys_clk);
        #1;
        for (j = 0; j < 4; j = j + 1)
          n[j] = n[j] + ck[j];
        n[4] = n[4] + op;
        n[5] = n[5] + cc;
      end
    end
  endtask
  task t_off;
    begin
      run(8);
      run(64);
      chk(n[0] + n[1] + n[2] + n[3] === 0, "gated");
      chk(gate === 1'b0, "gate");
    end
  endtask
  task t_div;
    begin
      wr(4'h0, 16'h0001);
      for (i = 0; i < 8; i = i + 1) begin
        wr(4'h1, i[15:0]);
        run(8);
        run(256);
        chk(n[0] === (256 >> i), "div");
        chk(n[4] === n[0], "sel0");
        chk(n[5] === n[0], "count");
      end
      chk(gate === 1'b1, "gate");
      rd(4'h0, 16'h0001);
      wr(4'h3, 16'hFFFF);
      rd(4'h3, 16'h0001);
    end
  endtask
  task t_sel;
    begin
      wr(4'h1, 16'h0210);
      for (i = 0; i < 4; i = i + 1) begin
        wr(4'h2, {i[1:0], 14'h0000});
        k = (i == 1) ? 2 : ((i == 2) ? 1 : i);
        run(8);
        run(512);
        chk(n[4] === n[k] && n[k] > 0, "sel");
      end
    end
  endtask
  task t_modes;
    begin
      wr(4'h2, 16'hFFFF);
      rd(4'h2, 16'hD7CF);
      rd(4'h5, 16'h0000);
      for (i = 0; i < 16; i = i + 1) begin
        m = i[3:0];
        wr(4'h2, {12'h000, m});
        run(4);
        chk(bad === !LEG[m], "bad");
        if (LEG[m])
          chk(up === UPM[m], "up");
      end
    end
  endtask
  task pulses(input integer p, input integer e);
    begin
      fork
        run(48);
        repeat (p) begin
          @(posedge i_sys_clk);
          i_chan_zero_timer_input <= 1'b1;
          repeat (5) @(posedge i_sys_clk);
          i_chan_zero_timer_input <= 1'b0;
          repeat (5) @(posedge i_sys_clk);
        end
      join
      chk(n[5] === e, "edges");
    end
  endtask
  task t_pin;
    begin
      wr(4'h2, 16'h1040);
      run(8);
      run(16);
      chk(n[5] === 0, "quiet");
      pulses(3, 3);
      wr(4'h2, 16'h1080);
      run(8);
      pulses(2, 4);
      wr(4'h2, 16'h1000);
      run(8);
      pulses(2, 2);
    end
  endtask
  task tally_and_finish;
    begin
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    rd(4'h2, 16'h0001);
    t_off;
    t_div;
    t_sel;
    t_modes;
    t_pin;
    wr(4'h0, 16'h0000);
    t_off;
    tally_and_finish;
  end
endmodule // testbench
bind tps_top tps_checker chk_i (.*);
